// >>> hw/sff_regs.svh
// sff_regs.svh: opcodes, pin patterns and counts of the fast serial flash port
// assumes: included by bare name wherever these names are used
`ifndef SFF_REGS_SVH
`define SFF_REGS_SVH

`define SFF_OP_CONT_LEGACY 8'hE8
`define SFF_OP_CONT_FAST   8'h0B
`define SFF_OP_CONT_LOWPWR 8'h01
`define SFF_OP_CONT_LOWFRQ 8'h03
`define SFF_OP_PAGE_READ   8'hD2
`define SFF_OP_DUAL_READ   8'h3B
`define SFF_OP_QUAD_READ   8'h6B
`define SFF_OP_BUF1_READ   8'hD4
`define SFF_OP_BUF2_READ   8'hD6
`define SFF_OP_BUF1_SLOW   8'hD1
`define SFF_OP_BUF2_SLOW   8'hD3
`define SFF_OP_PROT_READ   8'h32
`define SFF_OP_LOCK_READ   8'h35
`define SFF_OP_SECU_READ   8'h77
`define SFF_OP_STAT_READ   8'hD7
`define SFF_OP_IDENT_READ  8'h9F

`define SFF_OPC_LAST       4'h7
`define SFF_LEFT_X1        3'h7
`define SFF_LEFT_X2        3'h3
`define SFF_LEFT_X4        3'h1
`define SFF_OE_NONE        4'h0
`define SFF_OE_X1          4'h2
`define SFF_OE_X2          4'h3
`define SFF_OE_X4          4'hF
`define SFF_OUT_IDLE       4'h0

`endif

// >>> hw/sff_pkg.sv
// sff_pkg.sv: types of the fast serial flash port
// assumes: compiled before every design file
package sff_pkg;

    typedef enum logic [3:0] {
        SFF_CMD_NONE, SFF_CMD_CONT, SFF_CMD_PAGE, SFF_CMD_DUAL,
        SFF_CMD_QUAD, SFF_CMD_BUF, SFF_CMD_BUF_SLOW, SFF_CMD_PROT,
        SFF_CMD_LOCK, SFF_CMD_SECU, SFF_CMD_STAT, SFF_CMD_IDENT
    } sff_cmd_kind_t;

    typedef enum logic [3:0] {
        SFF_ST_IDLE  = 4'h1,
        SFF_ST_USER  = 4'h2,
        SFF_ST_STAT  = 4'h4,
        SFF_ST_IDENT = 4'h8
    } sff_core_st_t;

    typedef enum logic [1:0] {
        SFF_LANE_X1, SFF_LANE_X2, SFF_LANE_X4
    } sff_lanes_t;

    typedef struct packed {
        logic          valid;
        sff_cmd_kind_t kind;
        logic          buf_sel;
        logic          low_power;
        logic [7:0]    opcode;
    } sff_cmd_t;

    typedef struct packed {
        logic [3:0] o;
        logic [3:0] oe;
    } sff_pins_t;

    typedef struct packed {
        logic [6:0] rx_sh;
        logic [3:0] bit_cnt;
        logic       rsp;
        sff_lanes_t lanes;
        logic [7:0] tx_sh;
        logic [2:0] tx_left;
        logic [3:0] cur;
    } sff_link_t;

    typedef struct packed {
        logic       tgl;
        logic [7:0] op;
    } sff_keep_t;

    typedef struct packed {
        sff_core_st_t st;
        logic         tgl_seen;
        logic [2:0]   id_idx;
        logic         rsp_ready;
        sff_cmd_t     cmd;
    } sff_core_t;

endpackage

// >>> hw/sff_sync.sv
// sff_sync.sv: two flip-flop synchroniser for levels and gray words
// assumes: d_i changes at most one bit at a time when WIDTH > 1
`timescale 1ns/10ps

module sff_sync #(
    parameter int WIDTH = 1
) (
    // clock and resets
    input  wire logic             clk_i,
    input  wire logic             arst_i,
    input  wire logic             srst_i,
    // level in and out
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] q;
    } sff_sync_st_t;

    sff_sync_st_t st_r;
    sff_sync_st_t st_nxt;

    always_comb begin
        st_nxt.meta = d_i;
        st_nxt.q    = st_r.meta;
    end

    always_ff @(posedge clk_i or posedge arst_i) begin
        if (arst_i) begin
            st_r <= '0;
        end else if (srst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_o = st_r.q;

endmodule // sff_sync

// >>> hw/sff_fifo.sv
// sff_fifo.sv: dual clock fifo with gray pointers, valid and ready on both sides
// assumes: DEPTH is a power of two; write side resets synchronously, read side asynchronously
`timescale 1ns/10ps

module sff_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8,
    parameter int AW    = $clog2(DEPTH)
) (
    // write side
    input  wire logic          wclk_i,
    input  wire logic          wrst_i,
    input  wire logic          wvalid_i,
    output logic               wready_o,
    input  wire logic [W-1:0]  wdata_i,
    output logic      [AW:0]   wlevel_o,
    // read side
    input  wire logic          rclk_i,
    input  wire logic          rrst_i,
    output logic               rvalid_o,
    input  wire logic          rready_i,
    output logic      [W-1:0]  rdata_o
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             bin;
        logic [AW:0]             gray;
    } sff_fifo_w_t;

    typedef struct packed {
        logic [AW:0] bin;
        logic [AW:0] gray;
    } sff_fifo_r_t;

    sff_fifo_w_t w_r;
    sff_fifo_w_t w_nxt;
    sff_fifo_r_t r_r;
    sff_fifo_r_t r_nxt;
    logic [AW:0] rgray_w;
    logic [AW:0] wgray_r;

    function automatic logic [AW:0] g2b(input logic [AW:0] g);
        logic [AW:0] b;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    assign wlevel_o = w_r.bin - g2b(rgray_w);
    assign wready_o = (wlevel_o != (AW+1)'(DEPTH));
    assign rvalid_o = (g2b(wgray_r) != r_r.bin);
    assign rdata_o  = w_r.mem[r_r.bin[AW-1:0]];

    always_comb begin
        w_nxt = w_r;
        if (wvalid_i && wready_o) begin
            w_nxt.mem[w_r.bin[AW-1:0]] = wdata_i;
            w_nxt.bin  = w_r.bin + 1'b1;
            w_nxt.gray = w_nxt.bin ^ (w_nxt.bin >> 1);
        end
    end

    always_comb begin
        r_nxt = r_r;
        if (rvalid_o && rready_i) begin
            r_nxt.bin  = r_r.bin + 1'b1;
            r_nxt.gray = r_nxt.bin ^ (r_nxt.bin >> 1);
        end
    end

    always_ff @(posedge wclk_i) begin
        if (wrst_i) begin
            w_r <= '0;
        end else begin
            w_r <= w_nxt;
        end
    end

    always_ff @(posedge rclk_i or posedge rrst_i) begin
        if (rrst_i) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    sff_sync #(.WIDTH(AW + 1)) u_rsync (
        .clk_i  (wclk_i),
        .arst_i (1'b0),
        .srst_i (wrst_i),
        .d_i    (r_r.gray),
        .q_o    (rgray_w)
    );

    sff_sync #(.WIDTH(AW + 1)) u_wsync (
        .clk_i  (rclk_i),
        .arst_i (rrst_i),
        .srst_i (1'b0),
        .d_i    (w_r.gray),
        .q_o    (wgray_r)
    );

endmodule // sff_fifo

// >>> hw/sff_flash_port.sv
// sff_flash_port.sv: slave side of the fast serial command port of a page flash
// assumes: host drives sck_i, cs_n_i, io_i; storage logic answers on the rsp_* stream
`timescale 1ns/10ps
`include "sff_regs.svh"

module sff_flash_port #(
    parameter int                     FIFO_DEPTH = 8,
    parameter int                     ID_LEN     = 4,
    // identity bytes, value arbitrary
    parameter logic [ID_LEN-1:0][7:0] ID_BYTES   = 32'h5A01_2203
) (
    // core clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         reset_i,
    // flash pins, sck_i clocks the link side
    input  wire logic         sck_i,
    input  wire logic         cs_n_i,
    input  wire logic         rst_n_i,
    input  wire logic [3:0]   io_i,
    output logic      [3:0]   io_o,
    output logic      [3:0]   io_oe_o,
    // decoded command
    output sff_pkg::sff_cmd_t cmd_o,
    // status byte for the status read
    input  wire logic [7:0]   status_i,
    // response bytes from storage
    input  wire logic [7:0]   rsp_data_i,
    input  wire logic         rsp_valid_i,
    output logic              rsp_ready_o
);

    localparam int         LVL_W   = $clog2(FIFO_DEPTH) + 1;
    localparam logic [2:0] ID_LAST = 3'(ID_LEN - 1);
    localparam logic [LVL_W:0] DEPTH_L = (LVL_W+1)'(FIFO_DEPTH);

    sff_pkg::sff_link_t lk_r;
    sff_pkg::sff_link_t lk_nxt;
    sff_pkg::sff_keep_t kp_r;
    sff_pkg::sff_keep_t kp_nxt;
    sff_pkg::sff_pins_t pn_r;
    sff_pkg::sff_pins_t pn_nxt;
    sff_pkg::sff_core_t co_r;
    sff_pkg::sff_core_t co_nxt;

    logic             pin_rst;
    logic             frame_rst;
    logic             co_rst;
    logic [2:0]       sy_q;
    logic [7:0]       opc;
    logic [7:0]       src;
    logic [7:0]       shn;
    logic [3:0]       cur;
    logic [2:0]       left;
    logic             f_wvalid;
    logic             f_wready;
    logic [7:0]       f_wdata;
    logic [LVL_W-1:0] f_level;
    logic             f_rvalid;
    logic             f_rready;
    logic [7:0]       f_rdata;
    logic             push;
    logic [LVL_W:0]   lvl_sum;

    // link side resets: whole link on the pin, frame logic while deselected
    assign pin_rst   = ~rst_n_i;
    assign frame_rst = cs_n_i | pin_rst;
    assign opc       = {lk_r.rx_sh, io_i[0]};

    // link side, rising edge of the serial clock
    always_comb begin
        lk_nxt   = lk_r;
        kp_nxt   = kp_r;
        f_rready = 1'b0;
        src      = (lk_r.tx_left == 3'h0) ? f_rdata : lk_r.tx_sh;
        case (lk_r.lanes)
            sff_pkg::SFF_LANE_X4: begin
                cur  = src[7:4];
                shn  = {src[3:0], 4'h0};
                left = `SFF_LEFT_X4;
            end
            sff_pkg::SFF_LANE_X2: begin
                cur  = {2'h0, src[7:6]};
                shn  = {src[5:0], 2'h0};
                left = `SFF_LEFT_X2;
            end
            default: begin
                cur  = {2'h0, src[7], 1'b0};
                shn  = {src[6:0], 1'b0};
                left = `SFF_LEFT_X1;
            end
        endcase
        if (!lk_r.rsp) begin
            // command byte, msb first
            lk_nxt.rx_sh   = opc[6:0];
            lk_nxt.bit_cnt = lk_r.bit_cnt + 4'h1;
            // drop bytes left over from an earlier frame
            f_rready       = 1'b1;
            if (lk_r.bit_cnt == `SFF_OPC_LAST) begin
                kp_nxt.op  = opc;
                kp_nxt.tgl = ~kp_r.tgl;
                lk_nxt.rsp = 1'b1;
                case (opc)
                    `SFF_OP_DUAL_READ: lk_nxt.lanes = sff_pkg::SFF_LANE_X2;
                    `SFF_OP_QUAD_READ: lk_nxt.lanes = sff_pkg::SFF_LANE_X4;
                    default:           lk_nxt.lanes = sff_pkg::SFF_LANE_X1;
                endcase
            end
        end else if (lk_r.tx_left != 3'h0) begin
            lk_nxt.cur     = cur;
            lk_nxt.tx_sh   = shn;
            lk_nxt.tx_left = lk_r.tx_left - 3'h1;
        end else if (f_rvalid) begin
            f_rready       = 1'b1;
            lk_nxt.cur     = cur;
            lk_nxt.tx_sh   = shn;
            lk_nxt.tx_left = left;
        end else begin
            lk_nxt.cur = `SFF_OUT_IDLE;
        end
    end

    always_ff @(posedge sck_i or posedge frame_rst) begin
        if (frame_rst) begin
            lk_r <= '0;
        end else begin
            lk_r <= lk_nxt;
        end
    end

    // opcode and its toggle outlive the frame
    always_ff @(posedge sck_i or posedge pin_rst) begin
        if (pin_rst) begin
            kp_r <= '0;
        end else begin
            kp_r <= kp_nxt;
        end
    end

    // pin drivers, falling edge of the serial clock
    always_comb begin
        pn_nxt.o  = lk_r.cur;
        pn_nxt.oe = `SFF_OE_NONE;
        if (lk_r.rsp) begin
            case (lk_r.lanes)
                sff_pkg::SFF_LANE_X4: pn_nxt.oe = `SFF_OE_X4;
                sff_pkg::SFF_LANE_X2: pn_nxt.oe = `SFF_OE_X2;
                default:              pn_nxt.oe = `SFF_OE_X1;
            endcase
        end
    end

    // new bits appear right after the fall, valid within the low phase
    always_ff @(negedge sck_i or posedge frame_rst) begin
        if (frame_rst) begin
            pn_r <= '0;
        end else begin
            pn_r <= pn_nxt;
        end
    end

    assign io_o    = pn_r.o;
    assign io_oe_o = pn_r.oe;

    // toggle, select and reset pin into the core clock
    sff_sync #(.WIDTH(3)) u_sync (
        .clk_i  (ref_clk_i),
        .arst_i (1'b0),
        .srst_i (reset_i),
        .d_i    ({kp_r.tgl, cs_n_i, rst_n_i}),
        .q_o    (sy_q)
    );

    assign co_rst = reset_i | ~sy_q[0];

    // opcode decode
    function automatic sff_pkg::sff_cmd_t decode(input logic [7:0] op);
        sff_pkg::sff_cmd_t c;
        c        = '0;
        c.valid  = 1'b1;
        c.opcode = op;
        case (op)
            `SFF_OP_CONT_LEGACY: c.kind = sff_pkg::SFF_CMD_CONT;
            `SFF_OP_CONT_FAST:   c.kind = sff_pkg::SFF_CMD_CONT;
            `SFF_OP_CONT_LOWFRQ: c.kind = sff_pkg::SFF_CMD_CONT;
            `SFF_OP_CONT_LOWPWR: begin
                c.kind      = sff_pkg::SFF_CMD_CONT;
                c.low_power = 1'b1;
            end
            `SFF_OP_PAGE_READ:   c.kind = sff_pkg::SFF_CMD_PAGE;
            `SFF_OP_DUAL_READ:   c.kind = sff_pkg::SFF_CMD_DUAL;
            `SFF_OP_QUAD_READ:   c.kind = sff_pkg::SFF_CMD_QUAD;
            `SFF_OP_BUF1_READ:   c.kind = sff_pkg::SFF_CMD_BUF;
            `SFF_OP_BUF2_READ: begin
                c.kind    = sff_pkg::SFF_CMD_BUF;
                c.buf_sel = 1'b1;
            end
            `SFF_OP_BUF1_SLOW:   c.kind = sff_pkg::SFF_CMD_BUF_SLOW;
            `SFF_OP_BUF2_SLOW: begin
                c.kind    = sff_pkg::SFF_CMD_BUF_SLOW;
                c.buf_sel = 1'b1;
            end
            `SFF_OP_PROT_READ:   c.kind = sff_pkg::SFF_CMD_PROT;
            `SFF_OP_LOCK_READ:   c.kind = sff_pkg::SFF_CMD_LOCK;
            `SFF_OP_SECU_READ:   c.kind = sff_pkg::SFF_CMD_SECU;
            `SFF_OP_STAT_READ:   c.kind = sff_pkg::SFF_CMD_STAT;
            `SFF_OP_IDENT_READ:  c.kind = sff_pkg::SFF_CMD_IDENT;
            default:             c.kind = sff_pkg::SFF_CMD_NONE;
        endcase
        return c;
    endfunction

    // core side: answer source and command report
    always_comb begin
        co_nxt           = co_r;
        co_nxt.cmd.valid = 1'b0;
        f_wvalid         = 1'b0;
        f_wdata          = 8'h00;
        case (co_r.st)
            sff_pkg::SFF_ST_USER: begin
                f_wvalid = rsp_valid_i & co_r.rsp_ready;
                f_wdata  = rsp_data_i;
            end
            sff_pkg::SFF_ST_STAT: begin
                f_wvalid = 1'b1;
                f_wdata  = status_i;
            end
            sff_pkg::SFF_ST_IDENT: begin
                f_wvalid = 1'b1;
                f_wdata  = ID_BYTES[ID_LAST - co_r.id_idx];
                if (f_wready) begin
                    co_nxt.id_idx = co_r.id_idx + 3'h1;
                    if (co_r.id_idx == ID_LAST) begin
                        co_nxt.st = sff_pkg::SFF_ST_IDLE;
                    end
                end
            end
            default: begin
                f_wvalid = 1'b0;
            end
        endcase
        // a new opcode from the link
        if (sy_q[2] != co_r.tgl_seen) begin
            co_nxt.tgl_seen = sy_q[2];
            co_nxt.cmd      = decode(kp_r.op);
            co_nxt.id_idx   = 3'h0;
            case (co_nxt.cmd.kind)
                sff_pkg::SFF_CMD_STAT:  co_nxt.st = sff_pkg::SFF_ST_STAT;
                sff_pkg::SFF_CMD_IDENT: co_nxt.st = sff_pkg::SFF_ST_IDENT;
                sff_pkg::SFF_CMD_NONE:  co_nxt.st = sff_pkg::SFF_ST_IDLE;
                default:                co_nxt.st = sff_pkg::SFF_ST_USER;
            endcase
        end
        // deselect ends any answer
        if (sy_q[1]) begin
            co_nxt.st = sff_pkg::SFF_ST_IDLE;
        end
        // ready only with room left after this cycle's push
        co_nxt.rsp_ready = (co_nxt.st == sff_pkg::SFF_ST_USER) && (lvl_sum < DEPTH_L);
    end

    assign push    = f_wvalid & f_wready;
    assign lvl_sum = {1'b0, f_level} + {{LVL_W{1'b0}}, push};

    always_ff @(posedge ref_clk_i) begin
        if (co_rst) begin
            co_r    <= '0;
            co_r.st <= sff_pkg::SFF_ST_IDLE;
        end else begin
            co_r <= co_nxt;
        end
    end

    assign cmd_o       = co_r.cmd;
    assign rsp_ready_o = co_r.rsp_ready;

    // answer bytes cross from the core to the link; both sides emptied between frames
    sff_fifo #(
        .W     (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .wclk_i   (ref_clk_i),
        .wrst_i   (co_rst | sy_q[1]),
        .wvalid_i (f_wvalid),
        .wready_o (f_wready),
        .wdata_i  (f_wdata),
        .wlevel_o (f_level),
        .rclk_i   (sck_i),
        .rrst_i   (frame_rst),
        .rvalid_o (f_rvalid),
        .rready_i (f_rready),
        .rdata_o  (f_rdata)
    );

endmodule // sff_flash_port

// >>> tb/sff_flash_port_properties.sv
// sff_flash_port_properties.sv: port checker for the fast serial flash port
// assumes: bound to sff_flash_port, sees its ports only
`timescale 1ns/10ps

module sff_flash_port_chk (
    // clocks and resets
    input wire logic              ref_clk_i,
    input wire logic              reset_i,
    input wire logic              sck_i,
    input wire logic              cs_n_i,
    input wire logic              rst_n_i,
    // link pins
    input wire logic [3:0]        io_i,
    input wire logic [3:0]        io_o,
    input wire logic [3:0]        io_oe_o,
    // core side
    input wire sff_pkg::sff_cmd_t cmd_o,
    input wire logic              rsp_valid_i,
    input wire logic              rsp_ready_o
);
    logic [3:0] rises_r;
    logic [7:0] op_r;
    logic [7:0] snap_r;
    logic [3:0] oe_exp;

    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            rises_r <= 4'h0;
            op_r    <= 8'h00;
            snap_r  <= 8'h00;
        end else begin
            rises_r <= (rises_r == 4'h9) ? rises_r : rises_r + 4'h1;
            op_r    <= (rises_r < 4'h8) ? {op_r[6:0], io_i[0]} : op_r;
            snap_r  <= {io_o, io_oe_o};
        end
    end
    assign oe_exp = (op_r == 8'h3B) ? 4'h3 : ((op_r == 8'h6B) ? 4'hF : 4'h2);

    property p_quiet_cmd;
        @(posedge sck_i) disable iff (cs_n_i || !rst_n_i) rises_r < 4'h8 |-> io_oe_o == 4'h0;
    endproperty
    a_quiet_cmd: assert property (p_quiet_cmd) else $error("enable in command byte");
    property p_lanes;
        @(posedge sck_i) disable iff (cs_n_i || !rst_n_i) rises_r > 4'h7 |-> io_oe_o == oe_exp;
    endproperty
    a_lanes: assert property (p_lanes) else $error("wrong lane enable");
    property p_on_fall;
        @(negedge sck_i) disable iff (cs_n_i || !rst_n_i)
        rises_r != 4'h0 |-> {io_o, io_oe_o} == snap_r;
    endproperty
    a_on_fall: assert property (p_on_fall) else $error("output moved on rise");
    property p_idle;
        @(posedge ref_clk_i) disable iff (reset_i) cs_n_i |-> {io_o, io_oe_o} == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("output while deselected");
    property p_pulse;
        @(posedge ref_clk_i) disable iff (reset_i) cmd_o.valid |=> !cmd_o.valid;
    endproperty
    a_pulse: assert property (p_pulse) else $error("command pulse too long");
    property p_reg_ready;
        @(posedge ref_clk_i) disable iff (reset_i)
        cmd_o.kind inside {sff_pkg::SFF_CMD_STAT, sff_pkg::SFF_CMD_IDENT} |-> !rsp_ready_o;
    endproperty
    a_reg_ready: assert property (p_reg_ready) else $error("ready on register read");
    property p_arr_ready;
        @(posedge ref_clk_i) disable iff (reset_i)
        cmd_o.valid && cmd_o.kind inside {sff_pkg::SFF_CMD_CONT, sff_pkg::SFF_CMD_QUAD}
        |-> ##[0:4] rsp_ready_o;
    endproperty
    a_arr_ready: assert property (p_arr_ready) else $error("no ready on array read");
    property p_flags;
        @(posedge ref_clk_i) disable iff (reset_i) cmd_o.valid |->
        cmd_o.buf_sel == (cmd_o.opcode inside {8'hD6, 8'hD3}) &&
        cmd_o.low_power == (cmd_o.opcode == 8'h01);
    endproperty
    a_flags: assert property (p_flags) else $error("buffer or power flag");
    property p_desel;
        @(posedge ref_clk_i) disable iff (reset_i) cs_n_i [*5] |-> !rsp_ready_o;
    endproperty
    a_desel: assert property (p_desel) else $error("ready after deselect");
    c_quad: cover property (@(posedge ref_clk_i) cmd_o.valid && cmd_o.kind == sff_pkg::SFF_CMD_QUAD);
    c_stat: cover property (@(posedge ref_clk_i) cmd_o.valid && cmd_o.kind == sff_pkg::SFF_CMD_STAT);
    c_full: cover property (@(posedge ref_clk_i) rsp_valid_i && !rsp_ready_o && !cs_n_i);
endmodule // sff_flash_port_chk

bind sff_flash_port sff_flash_port_chk u_chk (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
    .rst_n_i(rst_n_i), .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o), .cmd_o(cmd_o),
    .rsp_valid_i(rsp_valid_i), .rsp_ready_o(rsp_ready_o));

// >>> tb/sff_host_model.sv
// sff_host_model.sv: host master that clocks frames into the flash port
// assumes: tasks called one at a time; clock stands still between frames
`timescale 1ns/10ps

module sff_host_model (
    // pins toward the flash
    output logic            sck_o,
    output logic            cs_n_o,
    output logic      [3:0] io_o,
    // pins from the flash
    input  wire logic [3:0] dq_i,
    input  wire logic [3:0] dq_oe_i
);
    realtime    half;
    logic [3:0] oe_seen;
    logic [3:0] g;
    logic [7:0] rd [0:7];
    int         pg_ops;

    initial begin
        sck_o  = 1'b0;
        cs_n_o = 1'b1;
        io_o   = 4'h0;
        half   = 7.5;
        // no erase or program is issued, so no page rewrite falls due
        pg_ops = 0;
    end

    // one period; g is the group shown since the last fall
    task automatic tick(input logic d);
        sck_o = 1'b1;
        io_o <= {~io_o[3:1], d};
        #half;
        g       = dq_i;
        oe_seen = dq_oe_i;
        sck_o   = 1'b0;
        #half;
    endtask

    task automatic start(input logic [7:0] op, input logic m3);
        logic [7:0] s;
        half = (op == 8'h01) ? 40.0 : ((op == 8'h03) ? 12.5 : 7.5);
        s = op << 1;
        sck_o   = m3;
        io_o[0] = op[7];
        #half;
        cs_n_o = 1'b0;
        #half;
        if (m3) begin
            sck_o = 1'b0;
            #half;
        end
        repeat (8) begin
            tick(s[7]);
            s = s << 1;
        end
    endtask

    // waits for the first set top bit, then collects n bytes
    task automatic read(input int n, input logic [1:0] ln);
        logic [7:0] sh;
        int k;
        int got;
        sh = 8'h00;
        k = 0;
        got = 0;
        // bytes not collected before the limit stay unknown and miscompare
        foreach (rd[i]) rd[i] = 8'hxx;
        for (int t = 0; t < 300 && got < n; t++) begin
            tick(~io_o[0]);
            if (got > 0 || k > 0 || g[ln == 2'h2 ? 3 : 1]) begin
                sh = (ln == 2'h2) ? {sh[3:0], g} : (ln == 2'h1) ? {sh[5:0], g[1:0]} : {sh[6:0], g[1]};
                k++;
                if (k == (ln == 2'h2 ? 2 : (ln == 2'h1 ? 4 : 8))) begin
                    rd[got] = sh;
                    got++;
                    k = 0;
                end
            end
        end
    endtask

    task automatic stop;
        cs_n_o = 1'b1;
        #half;
        sck_o = 1'b0;
        #600;
    endtask
endmodule // sff_host_model

// >>> tb/tb_serial_flash_fast_spi_interface.sv
// tb_serial_flash_fast_spi_interface.sv: self-checking bench of the flash port
// assumes: host model makes the link clock, bench models storage
`timescale 1ns/10ps

module tb_serial_flash_fast_spi_interface;
    localparam logic [31:0] ID_VAL = 32'hA1B2_C3D4;  // arbitrary identity value
    logic              ref_clk_i;
    logic              reset_i;
    logic              sck_i;
    logic              cs_n_i;
    logic              rst_n_i;
    logic [3:0]        io_i;
    logic [3:0]        io_o;
    logic [3:0]        io_oe_o;
    sff_pkg::sff_cmd_t cmd_o;
    sff_pkg::sff_cmd_t last_cmd;
    logic [7:0]        status_i;
    logic [7:0]        rsp_data_i;
    logic              rsp_valid_i;
    logic              rsp_ready_o;
    logic [7:0]        pushed [$];
    int                n_cmd = 0;
    int                fails = 0;
    int                tests_run = 0;

    sff_flash_port #(.FIFO_DEPTH(8), .ID_LEN(4), .ID_BYTES(ID_VAL)) dut (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
        .rst_n_i(rst_n_i), .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o), .cmd_o(cmd_o),
        .status_i(status_i), .rsp_data_i(rsp_data_i), .rsp_valid_i(rsp_valid_i),
        .rsp_ready_o(rsp_ready_o));
    sff_host_model host (.sck_o(sck_i), .cs_n_o(cs_n_i), .io_o(io_i), .dq_i(io_o),
        .dq_oe_i(io_oe_o));

    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        if (cmd_o.valid === 1'b1) begin
            last_cmd <= cmd_o;
            n_cmd    <= n_cmd + 1;
        end
        if (rsp_valid_i && rsp_ready_o === 1'b1) begin
            pushed.push_back(rsp_data_i);
            rsp_data_i <= rsp_data_i + 8'h01;
        end
    end

    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic complete_run;
        if (fails == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic t_decode;
        logic [7:0] ops [17];
        logic [3:0] kinds [17];
        int n0;
        ops = '{8'hE8, 8'h0B, 8'h01, 8'h03, 8'hD2, 8'h3B, 8'h6B, 8'hD4, 8'hD6,
                8'hD1, 8'hD3, 8'h32, 8'h35, 8'h77, 8'hD7, 8'h9F, 8'h5C};
        kinds = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h5,
                  4'h6, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'h0};
        for (int i = 0; i < 17; i++) begin
            n0 = n_cmd;
            host.start(ops[i], 1'b0);
            #1000;
            host.stop();
            chk_byte("cmd_count", 8'h01, 8'(n_cmd - n0));
            chk_byte("cmd_kind", {4'h0, kinds[i]}, {4'h0, last_cmd.kind});
            chk_byte("cmd_opcode", ops[i], last_cmd.opcode);
            chk_byte("cmd_flags", {6'h00, ops[i] == 8'h01, ops[i] == 8'hD6 || ops[i] == 8'hD3},
                     {6'h00, last_cmd.low_power, last_cmd.buf_sel});
        end
    endtask

    task automatic do_read(input logic [7:0] op, input logic m3, input int n,
                           input logic [1:0] ln, input logic [3:0] oe_e, input logic [63:0] ex);
        int np;
        np = (op == 8'hD7 || op == 8'h9F) ? 0 : 8;
        @(posedge ref_clk_i);
        rsp_data_i <= 8'h80;
        pushed.delete();
        host.start(op, m3);
        #1500;
        chk_byte("pushes_to_full", 8'(np), 8'(pushed.size()));
        chk_byte("ready_when_full", 8'h00, {7'h00, rsp_ready_o});
        host.read(n, ln);
        host.stop();
        chk_byte("lane_enable", {4'h0, oe_e}, {4'h0, host.oe_seen});
        for (int i = 0; i < n; i++)
            chk_byte("read_byte", np > 0 ? pushed[i] : ex[63-8*i -: 8], host.rd[i]);
    endtask

    task automatic t_array_reads;
        do_read(8'h0B, 1'b0, 8, 2'h0, 4'h2, 64'h0);
        do_read(8'h3B, 1'b0, 8, 2'h1, 4'h3, 64'h0);
        do_read(8'h6B, 1'b0, 8, 2'h2, 4'hF, 64'h0);
    endtask

    task automatic t_status_mode3;
        do_read(8'hD7, 1'b1, 4, 2'h0, 4'h2, 64'hA5A5_A5A5_A5A5_A5A5);
    endtask

    task automatic t_ident;
        do_read(8'h9F, 1'b0, 5, 2'h0, 4'h2, {ID_VAL, 32'h0000_0000});
    endtask

    initial begin
        reset_i     <= 1'b1;
        rst_n_i     <= 1'b0;
        status_i    <= 8'hA5;
        rsp_data_i  <= 8'h80;
        rsp_valid_i <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rst_n_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        t_decode();
        t_array_reads();
        t_status_mode3();
        t_ident();
        complete_run();
    end

    initial begin
        #500000;
        fails++;
        complete_run();
    end
endmodule // tb_serial_flash_fast_spi_interface
